// >>> src/dfs_pkg.sv
package dfs_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_HZ    = 32'h017D7840;  // 25 MHz
    localparam int TICK_US   = 32'h000003E8;  // 1 ms qualification tick
    localparam int T_MOT_MS  = 32'h000003E8;  // 1 s motor/encoder
    localparam int T_SPD_MS  = 32'h000001F4;  // 0.5 s speed sensors
    localparam int T_COIL_MS = 32'h00000320;  // 0.8 s clutch coil

    // ------------------------------------------------------------
    // Fault channels
    // ------------------------------------------------------------
    localparam int NCH    = 5;
    localparam int CH_MOT = 0;
    localparam int CH_ENC = 1;
    localparam int CH_SPF = 2;
    localparam int CH_SPR = 3;
    localparam int CH_CLU = 4;
    localparam int QW     = 10;
    localparam logic [NCH-1:0][QW-1:0] QUAL_TICKS = {
        QW'(T_COIL_MS * 1000 / TICK_US),
        QW'(T_SPD_MS * 1000 / TICK_US),
        QW'(T_SPD_MS * 1000 / TICK_US),
        QW'(T_MOT_MS * 1000 / TICK_US),
        QW'(T_MOT_MS * 1000 / TICK_US)};
    // Encoder codes 0..8 valid
    localparam logic [15:0] ENC_VALID = 16'h01FF;

    // ------------------------------------------------------------
    // Clutch duty and touch-off source
    // ------------------------------------------------------------
    localparam logic [6:0] DUTY_MAX_PCT = 7'h58;  // 88 %
    localparam logic [1:0] TS_NORMAL    = 2'h0;
    localparam logic [1:0] TS_REAR      = 2'h1;
    localparam logic [1:0] TS_FRONT     = 2'h2;
    localparam logic [1:0] TS_ZERO      = 2'h3;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] A_STATUS = 8'h00;
    localparam logic [7:0] A_CODES  = 8'h04;
    localparam logic [7:0] A_CTRL   = 8'h08;
    localparam logic [1:0] R_OKAY   = 2'h0;
    localparam logic [1:0] R_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        S_MEMREQ, S_MEMWAIT, S_NVMREQ, S_NVMWAIT, S_RUN
    } dfs_state_t;

endpackage : dfs_pkg

// >>> src/dfs_supervisor.sv
// Register access over AXI4-Lite and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
// Overview of operation
// - Check inputs and outputs; a fault lights lamp, stores code.
// - Codes go to the tester only on request.
// - Test memories at ignition; on failure self-reset and retest.
// - Memory fault inhibits everything; lamp stays dark.
// - Then test calibration; failure: lamp, default calibration, no codes.
// - Calibration fault holds until ignition cycle.
// - Motor or encoder fault for one second: lamp, code.
// - Motor off: output to ground or open circuit.
// - Motor on: output to ground, outputs shorted, or open.
// - Encoder code outside nine valid codes, or line to ground.
// - Motor or encoder failure, no shift running: refuse shifts.
// - Failure with shift pending: cancel it, refuse later shifts.
// - Invalid code in shift: stop, drive toward high, refuse shifts.
// - Fault clear one second: normal operation, lamp off, code kept.
// - Motor fault while energized holds until ignition cycle.
// - One speed sensor bad 0.5 s: lamp; high range uses other, no slip.
// - Speed fault in low range: maximum duty until low range ends.
// - Speed fault blocks new shifts until ignition cycle.
// - Both speed sensors bad 0.5 s: lamp; high range zero speed, no slip.
// - Sensors healthy 0.5 s: normal, lamp off, code kept.
// - Coil open or grounded 0.8 s: lamp, torque control halted.
// - Coil healthy 0.8 s: normal, lamp off, code kept.
// - Maximum clutch duty is eighty-eight percent.
module dfs_supervisor
    import dfs_pkg::*;
#(
    parameter int TICK_CYC = CLK_HZ / 1000000 * TICK_US
) (
    input  wire logic        clock,            // Clock
    input  wire logic        rst_n,            // Ignition reset
    input  wire logic [7:0]  s_axi_awaddr,     // AW address
    input  wire logic        s_axi_awvalid,    // AW valid
    output logic             s_axi_awready,    // AW ready
    input  wire logic [31:0] s_axi_wdata,      // W data
    input  wire logic [3:0]  s_axi_wstrb,      // W strobes
    input  wire logic        s_axi_wvalid,     // W valid
    output logic             s_axi_wready,     // W ready
    output logic [1:0]       s_axi_bresp,      // B response
    output logic             s_axi_bvalid,     // B valid
    input  wire logic        s_axi_bready,     // B ready
    input  wire logic [7:0]  s_axi_araddr,     // AR address
    input  wire logic        s_axi_arvalid,    // AR valid
    output logic             s_axi_arready,    // AR ready
    output logic [31:0]      s_axi_rdata,      // R data
    output logic [1:0]       s_axi_rresp,      // R response
    output logic             s_axi_rvalid,     // R valid
    input  wire logic        s_axi_rready,     // R ready
    output logic             memTestStart,     // Memory test go
    input  wire logic        memTestDone,      // Memory test end
    input  wire logic        romPass,          // Program ok
    input  wire logic        ramPass,          // Work ok
    output logic             selfReset,        // Self reset
    output logic             nvmTestStart,     // Cal test go
    input  wire logic        nvmTestDone,      // Cal test end
    input  wire logic        nvmPass,          // Cal ok
    input  wire logic        motorOn,          // Motor energized
    input  wire logic        motHlGnd,         // HL to ground
    input  wire logic        motLhGnd,         // LH to ground
    input  wire logic        motHlLh,          // HL to LH short
    input  wire logic        motOpen,          // Motor open
    input  wire logic [3:0]  encCode,          // Encoder code
    input  wire logic [3:0]  encLineGnd,       // Line to ground
    input  wire logic        spdFrontBad,      // Front bad
    input  wire logic        spdRearBad,       // Rear bad
    input  wire logic        coilOpen,         // Coil open
    input  wire logic        coilGnd,          // Coil to ground
    input  wire logic        low_range,        // Low range
    input  wire logic        shiftPending,     // Shift waiting
    input  wire logic        shiftRun,         // Shift running
    input  wire logic        testerReq,        // Codes request
    output logic             fault_warning_lamp, // Lamp
    output logic             funcEnable,       // Functions on
    output logic             useDefaultCal,    // Default cal
    output logic             shiftInhibit,     // Refuse shifts
    output logic             shiftCancel,      // Cancel pulse
    output logic             stopShift,        // Halt shift
    output logic             driveToHigh,      // Motor to high
    output logic             slipSuspend,      // Slip off
    output logic [1:0]       touchSel,         // Speed source
    output logic             clutchDutyMax,    // Max duty
    output logic [6:0]       clutchDutyPct,    // Duty percent
    output logic             torqueHalt,       // Torque off
    output logic             codeStore,        // Stored pulse
    output logic [NCH-1:0]   txCodes,          // Tester codes
    output logic             txValid           // Tester pulse
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        dfs_state_t             state;
        logic [14:0]            tickCnt;
        logic [NCH-1:0][QW-1:0] cnt;
        logic [NCH-1:0]         qual;
        logic [NCH-1:0]         codes;
        logic                   nvmFault;
        logic                   motLatch;
        logic                   spdLock;
        logic                   dutyLatch;
        logic                   highLatch;
        logic                   codeOutEn;
        logic                   memStart;
        logic                   nvmStart;
        logic                   selfRst;
        logic                   cancel;
        logic                   store;
        logic                   txV;
        logic [NCH-1:0]         txC;
        logic                   lamp;
        logic                   funcEn;
        logic                   shInh;
        logic                   slipSus;
        logic [1:0]             touch;
        logic                   dutyMax;
        logic                   tHalt;
        logic                   awHeld;
        logic                   wHeld;
        logic [7:0]             awAddr;
        logic [31:0]            wData;
        logic [3:0]             wStrb;
        logic                   bV;
        logic [1:0]             bR;
        logic                   rV;
        logic [1:0]             rR;
        logic [31:0]            rD;
    } dfs_regs_t;

    dfs_regs_t r;
    dfs_regs_t next_r;

    logic                   tick;
    logic [NCH-1:0]         raw;
    logic [NCH-1:0]         qNext;
    logic [NCH-1:0][QW-1:0] cNext;
    logic                   running;
    logic                   motEnc;
    logic                   motEncNew;
    logic                   spdAny;
    logic [31:0]            statusWord;

    assign running = (r.state == S_RUN);
    assign tick    = (r.tickCnt == 15'(TICK_CYC - 1));

    // ------------------------------------------------------------
    // Raw fault conditions
    // ------------------------------------------------------------
    always_comb begin
        raw[CH_MOT] = motHlGnd | motLhGnd | motOpen;
        if (motorOn) begin
            raw[CH_MOT] = motHlGnd | motLhGnd | motHlLh | motOpen;
        end
        if (r.motLatch) begin
            raw[CH_MOT] = 1'b1;
        end
        raw[CH_ENC] = !ENC_VALID[encCode] | (|encLineGnd);
        raw[CH_SPF] = spdFrontBad;
        raw[CH_SPR] = spdRearBad;
        raw[CH_CLU] = coilOpen | coilGnd;
    end

    // ------------------------------------------------------------
    // Fault and recovery qualifiers
    // ------------------------------------------------------------
    for (genvar i = 0; i < NCH; i++) begin : g_qual
        always_comb begin
            qNext[i] = r.qual[i];
            cNext[i] = r.cnt[i];
            if (!running) begin
                qNext[i] = 1'b0;
                cNext[i] = '0;
            end else if (raw[i] == r.qual[i]) begin
                cNext[i] = '0;
            end else if (tick) begin
                if (r.cnt[i] == QUAL_TICKS[i] - 1'b1) begin
                    qNext[i] = raw[i];
                    cNext[i] = '0;
                end else begin
                    cNext[i] = r.cnt[i] + 1'b1;
                end
            end
        end
    end

    assign motEnc    = qNext[CH_MOT] | qNext[CH_ENC];
    assign motEncNew = motEnc & !(r.qual[CH_MOT] | r.qual[CH_ENC]);
    assign spdAny    = qNext[CH_SPF] | qNext[CH_SPR];

    assign statusWord = {18'h0, r.shInh, r.lamp, r.spdLock, r.motLatch,
                         r.nvmFault, r.qual, 1'h0, r.state};

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_r          = r;
        next_r.memStart = 1'b0;
        next_r.nvmStart = 1'b0;
        next_r.selfRst  = 1'b0;
        next_r.cancel   = 1'b0;
        next_r.store    = 1'b0;
        next_r.txV      = 1'b0;
        next_r.tickCnt  = tick ? '0 : r.tickCnt + 1'b1;
        next_r.qual     = qNext;
        next_r.cnt      = cNext;

        case (r.state)
            S_MEMREQ: begin
                next_r.memStart = 1'b1;
                next_r.state    = S_MEMWAIT;
            end
            S_MEMWAIT: begin
                if (memTestDone && romPass && ramPass) begin
                    next_r.state = S_NVMREQ;
                end else if (memTestDone) begin
                    next_r.selfRst = 1'b1;
                    next_r.state   = S_MEMREQ;
                end
            end
            S_NVMREQ: begin
                next_r.nvmStart = 1'b1;
                next_r.state    = S_NVMWAIT;
            end
            S_NVMWAIT: begin
                if (nvmTestDone) begin
                    next_r.nvmFault = !nvmPass;
                    next_r.state    = S_RUN;
                end
            end
            S_RUN: begin
                next_r.state = S_RUN;
            end
            default: begin
                next_r.state = S_MEMREQ;
            end
        endcase

        if (running) begin
            if (qNext[CH_MOT] && !r.qual[CH_MOT] && motorOn) begin
                next_r.motLatch = 1'b1;
            end
            if (motEncNew && shiftPending) begin
                next_r.cancel = 1'b1;
            end
            if (qNext[CH_ENC] && !r.qual[CH_ENC] && shiftRun) begin
                next_r.highLatch = 1'b1;
            end
            if (spdAny) begin
                next_r.spdLock = 1'b1;
            end
            // max duty until low range ends
            if (!low_range) begin
                next_r.dutyLatch = 1'b0;
            end else if (spdAny) begin
                next_r.dutyLatch = 1'b1;
            end
        end

        // Software erase of stored codes
        if (r.awHeld && r.wHeld && !r.bV && r.awAddr == A_CODES
            && r.wStrb[0]) begin
            next_r.codes = r.codes & ~r.wData[NCH-1:0];
        end
        if (r.awHeld && r.wHeld && !r.bV && r.awAddr == A_CTRL
            && r.wStrb[0]) begin
            next_r.codeOutEn = r.wData[0];
        end
        // store code on new fault, set wins
        if (running && !r.nvmFault && (|(qNext & ~r.qual))) begin
            next_r.codes = next_r.codes | (qNext & ~r.qual);
            next_r.store = 1'b1;
        end
        if (testerReq && running && r.codeOutEn) begin
            next_r.txV = 1'b1;
            next_r.txC = r.codes;
        end

        next_r.funcEn = (next_r.state == S_RUN);
        next_r.lamp = running && (r.nvmFault || (|qNext));
        next_r.shInh = running && (motEnc || r.highLatch || next_r.spdLock);
        next_r.slipSus = running && spdAny && !low_range;
        next_r.touch   = TS_NORMAL;
        if (running && !low_range) begin
            case ({qNext[CH_SPR], qNext[CH_SPF]})
                2'h1:    next_r.touch = TS_REAR;
                2'h2:    next_r.touch = TS_FRONT;
                2'h3:    next_r.touch = TS_ZERO;
                default: next_r.touch = TS_NORMAL;
            endcase
        end
        next_r.dutyMax = running && next_r.dutyLatch;
        next_r.tHalt   = running && qNext[CH_CLU];

        // AXI4-Lite write channel
        if (s_axi_awvalid && !r.awHeld && !r.bV) begin
            next_r.awHeld = 1'b1;
            next_r.awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !r.wHeld && !r.bV) begin
            next_r.wHeld = 1'b1;
            next_r.wData = s_axi_wdata;
            next_r.wStrb = s_axi_wstrb;
        end
        if (r.awHeld && r.wHeld && !r.bV) begin
            next_r.awHeld = 1'b0;
            next_r.wHeld  = 1'b0;
            next_r.bV     = 1'b1;
            next_r.bR     = (r.awAddr == A_CODES || r.awAddr == A_CTRL)
                          ? R_OKAY : R_SLVERR;
        end else if (r.bV && s_axi_bready) begin
            next_r.bV = 1'b0;
        end

        // AXI4-Lite read channel
        if (s_axi_arvalid && !r.rV) begin
            next_r.rV = 1'b1;
            next_r.rR = R_OKAY;
            next_r.rD = '0;
            case (s_axi_araddr)
                A_STATUS: next_r.rD = statusWord;
                A_CODES:  next_r.rD = 32'(r.codes);
                A_CTRL:   next_r.rD = 32'(r.codeOutEn);
                default:  next_r.rR = R_SLVERR;
            endcase
        end else if (r.rV && s_axi_rready) begin
            next_r.rV = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            r           <= '0;
            r.state     <= S_MEMREQ;
            r.codeOutEn <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign s_axi_awready      = !r.awHeld && !r.bV;
    assign s_axi_wready       = !r.wHeld && !r.bV;
    assign s_axi_bvalid       = r.bV;
    assign s_axi_bresp        = r.bR;
    assign s_axi_arready      = !r.rV;
    assign s_axi_rvalid       = r.rV;
    assign s_axi_rdata        = r.rD;
    assign s_axi_rresp        = r.rR;
    assign memTestStart       = r.memStart;
    assign selfReset          = r.selfRst;
    assign nvmTestStart       = r.nvmStart;
    assign fault_warning_lamp = r.lamp;
    assign funcEnable         = r.funcEn;
    assign useDefaultCal      = r.nvmFault;
    assign shiftInhibit       = r.shInh;
    assign shiftCancel        = r.cancel;
    assign stopShift          = r.highLatch;
    assign driveToHigh        = r.highLatch;
    assign slipSuspend        = r.slipSus;
    assign touchSel           = r.touch;
    assign clutchDutyMax      = r.dutyMax;
    assign clutchDutyPct      = r.dutyMax ? DUTY_MAX_PCT : 7'h00;
    assign torqueHalt         = r.tHalt;
    assign codeStore          = r.store;
    assign txCodes            = r.txC;
    assign txValid            = r.txV;

endmodule : dfs_supervisor

// >>> testbench/dfs_supervisor_assertions.sv
`timescale 1ns/1ns
module dfs_supervisor_assertions
    import dfs_pkg::*;
(
    input wire logic       clock,              // Clock
    input wire logic       rst_n,              // Reset
    input wire logic       memTestStart,       // Memory test start
    input wire logic       memTestDone,        // Memory test done
    input wire logic       romPass,            // Program memory good
    input wire logic       ramPass,            // Work memory good
    input wire logic       selfReset,          // Self reset
    input wire logic       nvmTestDone,        // Calibration test done
    input wire logic       nvmPass,            // Calibration good
    input wire logic       useDefaultCal,      // Default calibration
    input wire logic       fault_warning_lamp, // Lamp
    input wire logic       codeStore,          // Code stored
    input wire logic       shiftCancel,        // Cancel pulse
    input wire logic       shiftInhibit,       // Shift refusal
    input wire logic       stopShift,          // Shift halted
    input wire logic       driveToHigh,        // Drive to high
    input wire logic       clutchDutyMax,      // Maximum duty
    input wire logic [6:0] clutchDutyPct,      // Duty percent
    input wire logic       low_range           // Low range
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);

    retest_follows_a: assert property (selfReset |=> memTestStart)
        else $error("no retest after self reset");
    memfail_reset_a: assert property (
        memTestDone && !(romPass && ramPass) |-> ##[1:2] selfReset)
        else $error("failed memory test not reset");
    lamp_dark_a: assert property ((memTestStart || selfReset)
        |-> !fault_warning_lamp) else $error("lamp lit during memory test");
    cal_default_a: assert property (nvmTestDone && !nvmPass
        |-> ##[1:4] (useDefaultCal && fault_warning_lamp))
        else $error("calibration fault not handled");
    cal_nocode_a: assert property (useDefaultCal |-> !codeStore)
        else $error("code stored with calibration fault");
    cal_latched_a: assert property (useDefaultCal |=> useDefaultCal)
        else $error("calibration fault released");
    cancel_inhibit_a: assert property (shiftCancel
        |-> ##[0:1] shiftInhibit) else $error("cancel without refusal");
    high_latch_a: assert property (stopShift
        |-> driveToHigh ##1 stopShift) else $error("halt not held");
    duty_value_a: assert property (clutchDutyPct
        == (clutchDutyMax ? DUTY_MAX_PCT : 7'h00)) else $error("bad duty");
    duty_lowexit_a: assert property (clutchDutyMax && !low_range
        |=> !clutchDutyMax) else $error("max duty outside low range");
endmodule : dfs_supervisor_assertions

bind dfs_supervisor dfs_supervisor_assertions u_chk (.*);

// >>> testbench/dfs_memtest_model.sv
`timescale 1ns/1ns
module dfs_memtest_model (
    input  wire logic       clock,        // Clock
    input  wire logic       rst_n,        // Reset
    input  wire logic       memTestStart, // Start memory test
    input  wire logic       nvmTestStart, // Start calibration test
    input  wire logic [1:0] memFails,     // Failing attempts
    input  wire logic       nvmGood,      // Calibration memory good
    input  wire logic [7:0] lat,          // Answer delay, at least 1
    output logic            memTestDone,  // Memory test done
    output logic            romPass,      // Program memory good
    output logic            ramPass,      // Work memory good
    output logic            nvmTestDone,  // Calibration test done
    output logic            nvmPass       // Calibration good
);
    logic [7:0] memWait, nvmWait;
    logic [1:0] tries;

    always @(posedge clock) begin
        memTestDone <= 1'h0;
        nvmTestDone <= 1'h0;
        romPass     <= ~romPass;
        ramPass     <= ~ramPass;
        nvmPass     <= ~nvmPass;
        if (!rst_n) begin
            {memWait, nvmWait, tries}   <= '0;
            {romPass, ramPass, nvmPass} <= '0;
        end else begin
            if (memTestStart) memWait <= lat;
            else if (memWait != 8'h00) memWait <= memWait - 8'h01;
            if (nvmTestStart) nvmWait <= lat;
            else if (nvmWait != 8'h00) nvmWait <= nvmWait - 8'h01;
            if (memWait == 8'h01) begin
                memTestDone <= 1'h1;
                romPass     <= tries >= memFails;
                ramPass     <= tries + 2'h1 >= memFails;
                tries       <= tries + 2'h1;
            end
            if (nvmWait == 8'h01) begin
                nvmTestDone <= 1'h1;
                nvmPass     <= nvmGood;
            end
        end
    end
endmodule : dfs_memtest_model

// >>> testbench/drive_fault_supervisor_tb.sv
`timescale 1ns/1ns
module drive_fault_supervisor_tb;
    import dfs_pkg::*;
    localparam int TK = 4;
    logic        clock = 1'h0, rst_n = 1'h0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, lat = 8'h14;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
    logic [3:0]  s_axi_wstrb = 4'hF, encCode = 4'h0, encLineGnd = 4'h0;
    logic [1:0]  s_axi_bresp, s_axi_rresp, touchSel, rsp, memFails = 2'h2;
    logic [6:0]  clutchDutyPct;
    logic [NCH-1:0] txCodes, txSnap = '0;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, motorOn = 1'h0;
    logic motHlGnd = 1'h0, motLhGnd = 1'h0, motHlLh = 1'h0, motOpen = 1'h0;
    logic coilGnd = 1'h0, coilOpen = 1'h0, spdFrontBad = 1'h0;
    logic spdRearBad = 1'h0, low_range = 1'h0, shiftPending = 1'h0;
    logic shiftRun = 1'h0, testerReq = 1'h0, nvmGood = 1'h1;
    logic cancelSeen = 1'h0, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid, memTestStart, memTestDone, romPass;
    logic ramPass, selfReset, nvmTestStart, nvmTestDone, nvmPass;
    logic fault_warning_lamp, funcEnable, useDefaultCal, shiftInhibit;
    logic shiftCancel, stopShift, driveToHigh, slipSuspend, clutchDutyMax;
    logic torqueHalt, codeStore, txValid;
    int   failCount = 0, nCompared = 0, cycles = 0;

    dfs_supervisor #(.TICK_CYC(TK)) dut (.*);
    dfs_memtest_model model (.*);

    always #20 clock = ~clock;

    task automatic closeOut();
        $display("compared %0d mismatched %0d", nCompared, failCount);
        if (failCount == 0 && nCompared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : closeOut

    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (shiftCancel) cancelSeen <= 1'h1;
        if (txValid) txSnap <= txCodes;
        if (cycles == 50000) begin
            failCount++;
            closeOut();
        end
    end

    task automatic chk(input string nm, input logic [31:0] seen, exp);
        nCompared++;
        if (seen !== exp) begin
            failCount++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic hold(input int n);
        repeat (n * TK) @(posedge clock);
    endtask : hold

    // Lamp at n-2 and n+2 ticks
    task automatic qual(input string nm, input int n, input logic v);
        hold(n - 2);
        chk(nm, fault_warning_lamp, !v);
        hold(4);
        chk(nm, fault_warning_lamp, v);
    endtask : qual

    task automatic axiWr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid  <= 1'h1;
        s_axi_bready  <= 1'h1;
        do begin
            @(posedge clock);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (!s_axi_bvalid);
        rsp = s_axi_bresp;
        s_axi_bready <= 1'h0;
    endtask : axiWr

    task automatic axiRd(input logic [7:0] a);
        @(posedge clock);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready  <= 1'h1;
        do begin
            @(posedge clock);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (!s_axi_rvalid);
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'h0;
    endtask : axiRd

    initial begin
        repeat (12) @(posedge clock);
        rst_n <= 1'h1;
        hold(50);
        chk("run", funcEnable, 1'h1);
        axiRd(A_STATUS);
        chk("state", rd[2:0], 3'h4);
        chk("lamp", rd[12], 1'h0);
        axiRd(8'hF0);
        chk("unmapped", rsp, R_SLVERR);
        chk("tx idle", txSnap, 5'h00);
        $display("test startup done");
        shiftPending <= 1'h1;
        motHlGnd     <= 1'h1;
        qual("motor", 1000, 1'h1);
        chk("inhibit", shiftInhibit, 1'h1);
        chk("cancel", cancelSeen, 1'h1);
        shiftPending <= 1'h0;
        motHlGnd     <= 1'h0;
        qual("motor ok", 1000, 1'h0);
        chk("inhibit", shiftInhibit, 1'h0);
        axiRd(A_CODES);
        chk("code kept", rd[4:0], 5'h01);
        testerReq <= 1'h1;
        @(posedge clock);
        testerReq <= 1'h0;
        hold(1);
        chk("tx codes", txSnap, 5'h01);
        axiWr(A_CODES, 32'h1);
        chk("wr resp", rsp, R_OKAY);
        axiRd(A_CODES);
        chk("code clear", rd[4:0], 5'h00);
        $display("test motor done");
        low_range   <= 1'h1;
        spdFrontBad <= 1'h1;
        qual("speed", 500, 1'h1);
        chk("duty max", clutchDutyMax, 1'h1);
        chk("duty pct", clutchDutyPct, 7'h58);
        low_range <= 1'h0;
        hold(1);
        chk("duty off", clutchDutyMax, 1'h0);
        chk("use rear", touchSel, TS_REAR);
        chk("slip", slipSuspend, 1'h1);
        spdRearBad <= 1'h1;
        hold(502);
        chk("zero", touchSel, TS_ZERO);
        {spdFrontBad, spdRearBad} <= 2'h0;
        qual("speed ok", 500, 1'h0);
        chk("lock", shiftInhibit, 1'h1);
        $display("test speed done");
        coilOpen <= 1'h1;
        hold(700);
        coilOpen <= 1'h0;
        hold(1);
        coilOpen <= 1'h1;
        hold(700);
        qual("coil", 100, 1'h1);
        chk("halt", torqueHalt, 1'h1);
        coilOpen <= 1'h0;
        qual("coil ok", 800, 1'h0);
        chk("halt", torqueHalt, 1'h0);
        $display("test coil done");
        shiftRun <= 1'h1;
        motorOn  <= 1'h1;
        encCode  <= 4'h9;
        qual("encoder", 1000, 1'h1);
        hold(1);
        chk("to high", {stopShift, driveToHigh}, 2'h3);
        $display("test encoder done");
        {rst_n, nvmGood, shiftRun, motorOn, memFails} <= '0;
        encCode <= 4'h0;
        repeat (12) @(posedge clock);
        rst_n <= 1'h1;
        hold(50);
        chk("default cal", {useDefaultCal, fault_warning_lamp}, 2'h3);
        coilOpen <= 1'h1;
        hold(802);
        axiRd(A_CODES);
        chk("no code", rd[4:0], 5'h00);
        chk("cal held", useDefaultCal, 1'h1);
        $display("test calibration done");
        closeOut();
    end
endmodule : drive_fault_supervisor_tb
